// file: src/ubvc_pkg.sv
// Purpose: Shared constants and types for the unsigned byte vector compare unit
// Assumes: 64-bit general registers, 32-bit instructions
// Notes:   Register offsets are word aligned byte addresses on APB
package ubvc_pkg;
   localparam logic [5:0] MAJOR_OPCODE    = 6'h1F; // 011111
   localparam logic [5:0] FUNC_EIGHT_BYTE = 6'h15; // 010101
   localparam logic [5:0] FUNC_FOUR_BYTE  = 6'h11; // 010001
   localparam logic [4:0] SUB_GPR_EQ      = 5'h04;
   localparam logic [4:0] SUB_GPR_LT      = 5'h05;
   localparam logic [4:0] SUB_GPR_LE      = 5'h06;
   localparam logic [4:0] SUB_FLG_EQ      = 5'h00;
   localparam logic [4:0] SUB_FLG_LT      = 5'h01;
   localparam logic [4:0] SUB_FLG_LE      = 5'h02;
   localparam logic [4:0] SUB_BOTH_LE     = 5'h1A; // 11010, four-byte form writing both
   localparam int         COND_LSB        = 24;
   localparam int         MAJOR_LSB       = 26;
   localparam int         SUB_LSB         = 6;
   localparam int         DEST_LSB        = 11;
   localparam logic [11:0] OFF_CTRL       = 12'h000;
   localparam logic [11:0] OFF_COND       = 12'h004;
   localparam logic [11:0] OFF_STATUS     = 12'h008;
   localparam logic [11:0] OFF_MASK       = 12'h00C;
   localparam logic [1:0] CTRL_RESET      = 2'h0;
   localparam int         EV_DONE         = 0;
   localparam int         EV_RESV         = 1;
   localparam int         EV_DISABLED     = 2;
   typedef enum {UBVC_EQ, UBVC_LT, UBVC_LE} ubvc_cond_t;
   typedef struct packed {
      logic       valid;
      logic [31:0] instr;
      logic [63:0] opA;
      logic [63:0] opB;
   } ubvc_issue_t;
   typedef struct packed {
      logic       valid;
      logic       gprWrite;
      logic [4:0] dest;
      logic [63:0] data;
      logic       resvExc;
      logic       disabledExc;
   } ubvc_result_t;
endpackage

// file: src/ubvc_compare.sv
// Purpose: Unsigned byte vector compare execute unit with APB control registers
// Assumes: Issue port driven by decoder on mclk; one result per recognised valid issue, one cycle later
// Notes:   Condition field lives in the control register block reachable over APB
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
// Operation
// - Eight-byte to-register form: compare eight lanes, results low eight bits, upper zero
// - Lane i of A compared with lane i of B; highest lane to highest bit
// - Four-byte to-register form: four rightmost lanes, low four bits, rest zero
// - Conditions equal, below, not-above, all unsigned per byte
// - To-register subcodes 00100, 00101, 00110; destination in bits 15 to 11
// - Major opcode 011111; function 010101 eight-byte, 010001 four-byte
// - Eight-byte to-flags form writes condition bits 31 to 24
// - Four-byte to-flags form writes condition bits 27 to 24
// - Condition bits 31 to 28 undefined after four-lane flag writes
// - To-flags forms: destination 00000, subcodes 00000, 00001, 00010
// - Four-byte not-above both form writes flags 27..24 and low GPR bits
// - Reserved-instruction exception if absent, disabled exception if switched off
// - No exception ever depends on operand values
module ubvc_compare
   import ubvc_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire ubvc_issue_t  issue,
   output ubvc_result_t      result,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   input  wire logic [3:0]   pstrb,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   output logic              irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   logic [31:0] ins;
   logic        isMajor;
   logic        isEight;
   logic        isFour;
   logic [4:0]  sub;
   logic [4:0]  destSel;
   logic        gprForm;
   logic        flagForm;
   logic        bothForm;
   logic        known;
   ubvc_cond_t  cond;

   assign ins     = issue.instr;
   assign sub     = ins[SUB_LSB +: 5];
   assign destSel = ins[DEST_LSB +: 5];
   assign isMajor = ins[MAJOR_LSB +: 6] == MAJOR_OPCODE;
   assign isEight = isMajor && ins[5:0] == FUNC_EIGHT_BYTE;
   assign isFour  = isMajor && ins[5:0] == FUNC_FOUR_BYTE;
   assign gprForm = (isEight || isFour) &&
                    (sub == SUB_GPR_EQ || sub == SUB_GPR_LT || sub == SUB_GPR_LE);
   assign flagForm = (isEight || isFour) && destSel == 5'h00 &&
                     (sub == SUB_FLG_EQ || sub == SUB_FLG_LT || sub == SUB_FLG_LE);
   assign bothForm = isFour && sub == SUB_BOTH_LE;
   assign known    = gprForm || flagForm || bothForm;
   assign cond     = (sub[1:0] == 2'h0) ? UBVC_EQ :
                     (sub[1:0] == 2'h1) ? UBVC_LT : UBVC_LE;

   ////////////////////////////////////////////////////////////////////////////
   // Lane compare
   // Operand format is the issuer's duty; lanes are plain unsigned bytes
   logic [7:0] laneFlag;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : lane
         logic [7:0] a;
         logic [7:0] b;
         assign a = issue.opA[8*g +: 8];
         assign b = issue.opB[8*g +: 8];
         assign laneFlag[g] = (cond == UBVC_EQ) ? (a == b) :
                              (cond == UBVC_LT) ? (a <  b) : (a <= b);
      end
   endgenerate

   logic [63:0] gprData;
   assign gprData = isEight ? {56'h0, laneFlag} :
                              {60'h0, laneFlag[3:0]};

   ////////////////////////////////////////////////////////////////////////////
   // Registers: ctrl[0]=implemented, ctrl[1]=enabled
   logic [1:0]  ctrl;
   logic [7:0]  condField;
   logic [2:0]  status;
   logic [2:0]  mask;
   logic        implemented;
   logic        enabled;
   logic        doIssue;
   logic        excResv;
   logic        excDis;
   logic        execOk;
   logic        flagWrite;
   logic [7:0]  next_condField;
   logic [2:0]  events;

   assign implemented = ctrl[0];
   assign enabled     = ctrl[1];
   assign doIssue     = issue.valid && known;
   // Only control bits and a valid, decoded issue gate the exceptions, never operand data
   assign excResv     = doIssue && !implemented;
   assign excDis      = doIssue && implemented && !enabled;
   assign execOk      = doIssue && implemented && enabled;
   assign flagWrite   = execOk && (flagForm || bothForm);
   // Upper four flags are undefined after four-lane writes; cleared here
   assign next_condField = isEight ? laneFlag :
                                     {4'h0, laneFlag[3:0]};
   assign events = {excDis, excResv, execOk};

   logic apbWr;
   logic apbRd;
   logic mapped;
   logic [31:0] rdMux;
   assign apbWr  = psel && penable && pwrite && !pready;
   assign apbRd  = psel && penable && !pwrite && !pready;
   assign mapped = paddr == OFF_CTRL || paddr == OFF_COND ||
                   paddr == OFF_STATUS || paddr == OFF_MASK;
   assign rdMux  = (paddr == OFF_CTRL)   ? {30'h0, ctrl} :
                   (paddr == OFF_COND)   ? {condField, 24'h0} :
                   (paddr == OFF_STATUS) ? {29'h0, status} :
                   (paddr == OFF_MASK)   ? {29'h0, mask} : 32'h0;

   logic wrCtrl;
   logic wrCond;
   logic wrStat;
   logic wrMask;
   assign wrCtrl = apbWr && paddr == OFF_CTRL && pstrb[0];
   assign wrCond = apbWr && paddr == OFF_COND && pstrb[3];
   assign wrStat = apbWr && paddr == OFF_STATUS && pstrb[0];
   assign wrMask = apbWr && paddr == OFF_MASK && pstrb[0];

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl      <= CTRL_RESET;
         condField <= 8'h00;
         status    <= 3'h0;
         mask      <= 3'h0;
      end else begin
         if (wrCtrl)
            ctrl <= pwdata[1:0];
         // Instruction flag write takes priority over a racing bus write
         if (flagWrite)
            condField <= next_condField;
         else if (wrCond)
            condField <= pwdata[31:24];
         // Set wins over write-one-to-clear
         status <= (status & ~(wrStat ? pwdata[2:0] : 3'h0)) | events;
         if (wrMask)
            mask <= pwdata[2:0];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         result  <= '0;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end else begin
         result.valid       <= doIssue;
         result.gprWrite    <= execOk && (gprForm || bothForm);
         result.dest        <= destSel;
         result.data        <= gprData;
         result.resvExc     <= excResv;
         result.disabledExc <= excDis;
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata  <= apbRd ? rdMux : 32'h0;
         irq     <= |(((status & ~(wrStat ? pwdata[2:0] : 3'h0)) | events) & mask);
      end
   end

endmodule

// file: test/ubvc_compare_sva.sv
// Purpose: Port checks for ubvc_compare
// Assumes: Result registered one cycle after issue
// Notes:   Bound below
`timescale 1ns/1ps
module ubvc_compare_sva
   import ubvc_pkg::*;
(
   input wire logic         mclk,
   input wire logic         resetn,
   input wire ubvc_issue_t  issue,
   input wire ubvc_result_t result
);
   ubvc_issue_t pv;
   wire logic   gw = result.gprWrite;
   always_ff @(posedge mclk) pv <= issue;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_ans;
      issue.valid && {issue.instr[31:26], issue.instr[10:0]} == {MAJOR_OPCODE, SUB_GPR_EQ, FUNC_FOUR_BYTE}
      |=> result.valid;
   endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_dest; gw |-> result.dest == pv.instr[15:11]; endproperty
   a_dest: assert property (p_dest) else $error("dest");
   property p_top8; gw |-> result.data[63:8] == '0; endproperty
   a_top8: assert property (p_top8) else $error("upper bits");
   property p_top4; gw && pv.instr[5:0] == FUNC_FOUR_BYTE |-> result.data[63:4] == '0; endproperty
   a_top4: assert property (p_top4) else $error("four upper");
   property p_lane; gw && pv.instr[10:6] == SUB_GPR_EQ |-> result.data[0] == (pv.opA[7:0] == pv.opB[7:0]); endproperty
   a_lane: assert property (p_lane) else $error("lane 0");
   property p_below;
      gw && pv.instr[10:0] == {SUB_GPR_LT, FUNC_EIGHT_BYTE} |-> result.data[7] == (pv.opA[63:56] < pv.opB[63:56]);
   endproperty
   a_below: assert property (p_below) else $error("below");
   property p_flag; result.valid && pv.instr[15:6] == {5'h00, SUB_FLG_LT} |-> !gw; endproperty
   a_flag: assert property (p_flag) else $error("flag form wrote");
   property p_exc; result.resvExc |-> !gw && !result.disabledExc; endproperty
   a_exc: assert property (p_exc) else $error("exception");
endmodule
bind ubvc_compare ubvc_compare_sva i_ubvc_compare_sva (.mclk(mclk), .resetn(resetn), .issue(issue), .result(result));

// file: test/ubvc_issuer.sv
// Purpose: Issue-side model of the pipeline
// Assumes: One instruction per call, valid one cycle
// Notes:   Released fields are inverted, never left stale
`timescale 1ns/1ps
module ubvc_issuer
   import ubvc_pkg::*;
(
   input  wire logic   mclk,
   output ubvc_issue_t issue
);
   initial issue = '0;
   // Operands always arrive as packed unsigned bytes
   task automatic send(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b);
      @(posedge mclk);
      issue <= '{1'b1, i, a, b};
      @(posedge mclk);
      issue <= '{1'b0, ~i, ~a, ~b};
   endtask
endmodule

// file: test/ubvc_compare_bench.sv
// Purpose: Directed bench for ubvc_compare
// Assumes: Result one cycle after issue
// Notes:   Flag bits 31..28 after four-lane writes unchecked
`timescale 1ns/1ps
`define CHK(n, e, s) begin totalChecks++; if ((s) !== (e)) begin mismatches++; $display("BAD %s %h %h", n, e, s); end end
module ubvc_compare_bench
   import ubvc_pkg::*;
;
   localparam logic [63:0] A = 64'h00FF_10FE_7F01_FE05;
   localparam logic [63:0] B = 64'h01FF_0F01_7F00_FF05;
   localparam logic [5:0]  F8 = FUNC_EIGHT_BYTE;
   localparam logic [5:0]  F4 = FUNC_FOUR_BYTE;
   logic         mclk, pready, pslverr, irq, e;
   logic         resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]  paddr = '0;
   logic [31:0]  pwdata = '0, prdata, r;
   logic [63:0]  x;
   logic [7:0]   v;
   logic [4:0]   gs [3] = '{SUB_GPR_EQ, SUB_GPR_LT, SUB_GPR_LE};
   logic [4:0]   fs [3] = '{SUB_FLG_EQ, SUB_FLG_LT, SUB_FLG_LE};
   ubvc_issue_t  issue;
   ubvc_result_t res;
   int           mismatches = 0, totalChecks = 0;
   ubvc_issuer i_ubvc_issuer (.mclk(mclk), .issue(issue));
   ubvc_compare i_ubvc_compare (.mclk(mclk), .resetn(resetn), .issue(issue), .result(res), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   function automatic logic [7:0] expv(int c);
      for (int i = 0; i < 8; i++)
         expv[i] = c == 0 ? A[8*i+:8] == B[8*i+:8] : c == 1 ? A[8*i+:8] < B[8*i+:8] : A[8*i+:8] <= B[8*i+:8];
   endfunction
   // Flag forms carry no destination
   task automatic run(input logic [5:0] f, input logic [4:0] s);
      i_ubvc_issuer.send({MAJOR_OPCODE, 10'h041, (s < 5'h04 ? 5'h00 : 5'h03), s, f}, A, B);
      #1;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Ready is a one-cycle pulse: look at it on each edge, before the edge updates it
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic giveVerdict;
      $display("checks %0d mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #100000;
      mismatches++;
      giveVerdict;
   end
   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      run(F8, SUB_GPR_EQ);
      `CHK("absent", 1'b1, res.resvExc)
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      run(F4, SUB_FLG_EQ);
      `CHK("off", 1'b1, res.disabledExc)
      apb(1'b1, OFF_MASK, 32'h0000_0007);
      `CHK("masked", 1'b0, irq)
      repeat (2) @(posedge mclk);
      `CHK("irqOn", 1'b1, irq)
      apb(1'b1, OFF_STATUS, 32'h0000_0007);
      repeat (2) @(posedge mclk);
      `CHK("irqOff", 1'b0, irq)
      apb(1'b1, OFF_CTRL, 32'h0000_0003);
      apb(1'b1, OFF_COND, 32'hA500_0000);
      run(F8, SUB_GPR_LE);
      apb(1'b0, OFF_COND, '0);
      `CHK("kept", 32'hA500_0000, r)
      for (int c = 0; c < 3; c++) begin
         v = expv(c);
         for (int f = 0; f < 2; f++) begin
            x = f ? {60'h0, v[3:0]} : {56'h0, v};
            run(f ? F4 : F8, gs[c]);
            `CHK("gpr", x, res.data)
            run(f ? F4 : F8, fs[c]);
            apb(1'b0, OFF_COND, '0);
            `CHK("flags", x[7:0], f ? {4'h0, r[27:24]} : r[31:24])
         end
      end
      v = expv(2);
      run(F4, SUB_BOTH_LE);
      `CHK("both", {60'h0, v[3:0]}, res.data)
      apb(1'b0, OFF_COND, '0);
      `CHK("bothFlags", v[3:0], r[27:24])
      apb(1'b0, 12'h010, '0);
      `CHK("unmapped", 1'b1, e)
      giveVerdict;
   end
endmodule
